// [verilog/tmc_top.sv]
// Two timer/counters with four modes, reached over APB
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tmc_top (
	input wire logic MCLK, // Core clock, 125 MHz
	input wire logic RST_N, // Synchronous reset, active low
	input wire logic PSEL, // APB select
	input wire logic PENABLE, // APB access phase
	input wire logic PWRITE, // APB direction
	input wire logic [7:0] PADDR, // APB byte address
	input wire logic [31:0] PWDATA, // APB write data
	output logic [31:0] PRDATA, // APB read data
	output logic PREADY, // APB ready
	output logic PSLVERR, // APB error, unmapped address
	input wire logic EXT_IRQ_PIN_FIRST, // Gate pin of first timer
	input wire logic EXT_IRQ_PIN_SECOND, // Gate pin of second timer
	input wire logic COUNT_PIN_FIRST, // External count pin, first timer
	input wire logic COUNT_PIN_SECOND, // External count pin, second timer
	output logic OVERFLOW_FLAG_FIRST, // First overflow flag
	output logic OVERFLOW_FLAG_SECOND // Second overflow flag
);
	logic [7:0] timer_mode_reg;
	logic [2:0] turbo_sel;
	logic twelve_clk;
	logic run_bit_first;
	logic run_bit_second;
	logic [7:0] count_low_byte_first;
	logic [7:0] count_high_byte_first;
	logic [7:0] count_low_byte_second;
	logic [7:0] count_high_byte_second;
	logic [3:0] prescale;
	logic tick12;
	logic tick6;
	logic tick_first;
	logic tick_second;
	logic fall_first;
	logic fall_second;
	logic [1:0] mode_first;
	logic [1:0] mode_second;
	logic cnt_first;
	logic cnt_second;
	logic split_hi_cnt;
	logic set_first;
	logic set_second;
	logic acc_go;
	logic wr_go;
	logic [7:0] next_low_first;
	logic [7:0] next_high_first;
	logic [7:0] next_low_second;
	logic [7:0] next_high_second;
	tmc_pkg::tmc_step_t step_first;
	tmc_pkg::tmc_step_t step_second;
	tmc_pkg::tmc_apb_rsp_t next_rsp;

	// One counting step of a timer in the given mode
	function automatic tmc_pkg::tmc_step_t count_step(input logic [1:0] mode,
			input logic [7:0] hi, input logic [7:0] lo);
		tmc_pkg::tmc_step_t r;
		r.ovf = 1'b0;
		r.hi = hi;
		r.lo = lo;
		unique case (mode)
			tmc_pkg::MODE_13BIT: begin
				// Upper three low bits left as they are
				r.lo = {lo[7:5], 5'(lo[4:0] + 5'h01)};
				if (lo[4:0] == tmc_pkg::LOW5_MAX) begin
					r.hi = 8'(hi + 8'h01);
					r.ovf = (hi == tmc_pkg::BYTE_MAX);
				end
			end
			tmc_pkg::MODE_16BIT: begin
				r.lo = 8'(lo + 8'h01);
				if (lo == tmc_pkg::BYTE_MAX) begin
					r.hi = 8'(hi + 8'h01);
					r.ovf = (hi == tmc_pkg::BYTE_MAX);
				end
			end
			tmc_pkg::MODE_RELOAD: begin
				// High byte untouched, used as reload value
				r.lo = (lo == tmc_pkg::BYTE_MAX) ? hi : 8'(lo + 8'h01);
				r.ovf = (lo == tmc_pkg::BYTE_MAX);
			end
			tmc_pkg::MODE_SPLIT: begin
				r.lo = 8'(lo + 8'h01);
				r.ovf = (lo == tmc_pkg::BYTE_MAX);
			end
		endcase
		return r;
	endfunction : count_step

	// Address decode of a register write in the completing cycle
	function automatic logic wr_hit(input logic go, input logic [7:0] addr,
			input logic [7:0] off);
		return go && (addr == off);
	endfunction : wr_hit

	// External count pin conditioning
	tmc_fall_detect u_fall_first (
		.MCLK(MCLK),
		.RST_N(RST_N),
		.PIN(COUNT_PIN_FIRST),
		.FALL(fall_first)
	);

	tmc_fall_detect u_fall_second (
		.MCLK(MCLK),
		.RST_N(RST_N),
		.PIN(COUNT_PIN_SECOND),
		.FALL(fall_second)
	);

	// Shared prescaler, wraps every twelve clocks
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			prescale <= 4'h0;
		end else if (prescale == tmc_pkg::PRESCALE_LAST) begin
			prescale <= 4'h0;
		end else begin
			prescale <= 4'(prescale + 4'h1);
		end
	end

	// Time base per timer
	assign tick12 = (prescale == tmc_pkg::PRESCALE_LAST);
	assign tick6 = tick12 || (prescale == tmc_pkg::PRESCALE_HALF);
	assign tick_first = (twelve_clk || !turbo_sel[0]) ? tick12 : tick6;
	assign tick_second = (twelve_clk || !turbo_sel[1]) ? tick12 : tick6;

	// Mode and count enables
	assign mode_first = {timer_mode_reg[tmc_pkg::MODE_SEL_HIGH_FIRST],
		timer_mode_reg[tmc_pkg::MODE_SEL_LOW_FIRST]};
	assign mode_second = {timer_mode_reg[tmc_pkg::MODE_SEL_HIGH_SECOND],
		timer_mode_reg[tmc_pkg::MODE_SEL_LOW_SECOND]};
	assign cnt_first = run_bit_first
		&& (!timer_mode_reg[tmc_pkg::GATE_FIRST] || EXT_IRQ_PIN_FIRST)
		&& (timer_mode_reg[tmc_pkg::CT_SEL_FIRST] ? fall_first : tick_first);
	assign cnt_second = ((mode_first == tmc_pkg::MODE_SPLIT) || run_bit_second)
		&& (!timer_mode_reg[tmc_pkg::GATE_SECOND] || EXT_IRQ_PIN_SECOND)
		&& (timer_mode_reg[tmc_pkg::CT_SEL_SECOND] ? fall_second : tick_second)
		&& (mode_second != tmc_pkg::MODE_SPLIT);
	assign split_hi_cnt = (mode_first == tmc_pkg::MODE_SPLIT) && run_bit_second
		&& tick_first;
	assign step_first = count_step(mode_first, count_high_byte_first, count_low_byte_first);
	assign step_second = count_step(mode_second, count_high_byte_second,
		count_low_byte_second);

	// APB completion strobes
	assign acc_go = PSEL && PENABLE && PREADY;
	assign wr_go = acc_go && PWRITE;

	// Next counter values; software writes win over counting
	always_comb begin
		next_low_first = count_low_byte_first;
		next_high_first = count_high_byte_first;
		next_low_second = count_low_byte_second;
		next_high_second = count_high_byte_second;
		set_first = 1'b0;
		set_second = 1'b0;
		if (cnt_first) begin
			next_low_first = step_first.lo;
			next_high_first = step_first.hi;
			set_first = step_first.ovf;
		end
		if (split_hi_cnt) begin
			next_high_first = 8'(count_high_byte_first + 8'h01);
			set_second = (count_high_byte_first == tmc_pkg::BYTE_MAX);
		end
		if (cnt_second) begin
			next_low_second = step_second.lo;
			next_high_second = step_second.hi;
			if (mode_first != tmc_pkg::MODE_SPLIT) begin
				set_second = step_second.ovf;
			end
		end
		if (wr_hit(wr_go, PADDR, tmc_pkg::OFF_LOW_FIRST)) begin
			next_low_first = PWDATA[7:0];
		end
		if (wr_hit(wr_go, PADDR, tmc_pkg::OFF_HIGH_FIRST)) begin
			next_high_first = PWDATA[7:0];
		end
		if (wr_hit(wr_go, PADDR, tmc_pkg::OFF_LOW_SECOND)) begin
			next_low_second = PWDATA[7:0];
		end
		if (wr_hit(wr_go, PADDR, tmc_pkg::OFF_HIGH_SECOND)) begin
			next_high_second = PWDATA[7:0];
		end
	end

	// Count bytes, each its own register
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			count_low_byte_first <= tmc_pkg::COUNT_RST;
			count_high_byte_first <= tmc_pkg::COUNT_RST;
			count_low_byte_second <= tmc_pkg::COUNT_RST;
			count_high_byte_second <= tmc_pkg::COUNT_RST;
		end else begin
			count_low_byte_first <= next_low_first;
			count_high_byte_first <= next_high_first;
			count_low_byte_second <= next_low_second;
			count_high_byte_second <= next_high_second;
		end
	end

	// Configuration registers
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			timer_mode_reg <= tmc_pkg::TIMER_MODE_RST;
			turbo_sel <= tmc_pkg::TURBO_RST;
			twelve_clk <= 1'b0;
			run_bit_first <= 1'b0;
			run_bit_second <= 1'b0;
		end else begin
			if (wr_hit(wr_go, PADDR, tmc_pkg::OFF_TIMER_MODE)) begin
				timer_mode_reg <= PWDATA[7:0];
			end
			if (wr_hit(wr_go, PADDR, tmc_pkg::OFF_CLOCK_SPEED)) begin
				turbo_sel <= PWDATA[tmc_pkg::TURBO_SEL_THIRD:tmc_pkg::TURBO_SEL_FIRST];
			end
			if (wr_hit(wr_go, PADDR, tmc_pkg::OFF_OPTION)) begin
				twelve_clk <= PWDATA[tmc_pkg::TWELVE_CLK_OPT];
			end
			if (wr_hit(wr_go, PADDR, tmc_pkg::OFF_TIMER_CONTROL)) begin
				run_bit_first <= PWDATA[tmc_pkg::RUN_BIT_FIRST];
				run_bit_second <= PWDATA[tmc_pkg::RUN_BIT_SECOND];
			end
		end
	end

	// Overflow flags; a hardware set wins over a software clear
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			OVERFLOW_FLAG_FIRST <= 1'b0;
			OVERFLOW_FLAG_SECOND <= 1'b0;
		end else begin
			if (set_first) begin
				OVERFLOW_FLAG_FIRST <= 1'b1;
			end else if (wr_hit(wr_go, PADDR, tmc_pkg::OFF_TIMER_CONTROL)) begin
				OVERFLOW_FLAG_FIRST <= PWDATA[tmc_pkg::OVERFLOW_FLAG_FIRST];
			end
			if (set_second) begin
				OVERFLOW_FLAG_SECOND <= 1'b1;
			end else if (wr_hit(wr_go, PADDR, tmc_pkg::OFF_TIMER_CONTROL)) begin
				OVERFLOW_FLAG_SECOND <= PWDATA[tmc_pkg::OVERFLOW_FLAG_SECOND];
			end
		end
	end

	// Read mux and error decode for the pending access
	always_comb begin
		next_rsp.ready = PSEL && PENABLE && !PREADY;
		next_rsp.slverr = 1'b0;
		next_rsp.rdata = 32'h0000_0000;
		unique case (PADDR)
			tmc_pkg::OFF_TIMER_MODE: next_rsp.rdata[7:0] = timer_mode_reg;
			tmc_pkg::OFF_TIMER_CONTROL: begin
				next_rsp.rdata[tmc_pkg::RUN_BIT_FIRST] = run_bit_first;
				next_rsp.rdata[tmc_pkg::OVERFLOW_FLAG_FIRST] = OVERFLOW_FLAG_FIRST;
				next_rsp.rdata[tmc_pkg::RUN_BIT_SECOND] = run_bit_second;
				next_rsp.rdata[tmc_pkg::OVERFLOW_FLAG_SECOND] = OVERFLOW_FLAG_SECOND;
			end
			tmc_pkg::OFF_CLOCK_SPEED:
				next_rsp.rdata[tmc_pkg::TURBO_SEL_THIRD:tmc_pkg::TURBO_SEL_FIRST] = turbo_sel;
			tmc_pkg::OFF_LOW_FIRST: next_rsp.rdata[7:0] = count_low_byte_first;
			tmc_pkg::OFF_LOW_SECOND: next_rsp.rdata[7:0] = count_low_byte_second;
			tmc_pkg::OFF_HIGH_FIRST: next_rsp.rdata[7:0] = count_high_byte_first;
			tmc_pkg::OFF_HIGH_SECOND: next_rsp.rdata[7:0] = count_high_byte_second;
			tmc_pkg::OFF_OPTION: next_rsp.rdata[tmc_pkg::TWELVE_CLK_OPT] = twelve_clk;
			default: next_rsp.slverr = next_rsp.ready;
		endcase
		if (!next_rsp.ready) begin
			next_rsp.rdata = 32'h0000_0000;
		end
	end

	// Registered APB response, one wait state per access
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h0000_0000;
		end else begin
			PREADY <= next_rsp.ready;
			PSLVERR <= next_rsp.slverr;
			PRDATA <= next_rsp.rdata;
		end
	end

	// Checks
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	sequence apb_wait_s;
		PSEL && PENABLE && !PREADY;
	endsequence

	sequence apb_done_s;
		PREADY && PSEL && PENABLE;
	endsequence

	sequence wrap13_s;
		cnt_first && !wr_go && mode_first == tmc_pkg::MODE_13BIT
			&& count_high_byte_first == 8'hff && count_low_byte_first[4:0] == 5'h1f;
	endsequence

	apb_one_wait_a: assert property (apb_wait_s |=> apb_done_s)
		else $error("APB access not answered after one wait state");
	turbo_six_a: assert property (tick6 |=> !tick6 [*5] ##1 tick6)
		else $error("turbo tick spacing not six clocks");
	option_twelve_a: assert property (twelve_clk && tick_first |-> prescale == 4'hb)
		else $error("twelve clock option did not override turbo");
	wrap_mode0_a: assert property (wrap13_s |=> count_high_byte_first == 8'h00
			&& count_low_byte_first[4:0] == 5'h00 && OVERFLOW_FLAG_FIRST
			&& count_low_byte_first[7:5] == $past(count_low_byte_first[7:5]))
		else $error("mode 0 rollover wrong");
	wrap_mode1_a: assert property (cnt_second && !wr_go
			&& mode_second == tmc_pkg::MODE_16BIT && mode_first != tmc_pkg::MODE_SPLIT
			&& {count_high_byte_second, count_low_byte_second} == 16'hffff
			|=> {count_high_byte_second, count_low_byte_second} == 16'h0000
			&& OVERFLOW_FLAG_SECOND)
		else $error("mode 1 rollover wrong");
	reload_low_a: assert property (cnt_first && !wr_go
			&& mode_first == tmc_pkg::MODE_RELOAD && count_low_byte_first == 8'hff
			|=> count_low_byte_first == $past(count_high_byte_first)
			&& $stable(count_high_byte_first) && OVERFLOW_FLAG_FIRST)
		else $error("mode 2 reload wrong");
	split_high_a: assert property (split_hi_cnt && !wr_go
			&& count_high_byte_first == 8'hff
			|=> count_high_byte_first == 8'h00 && OVERFLOW_FLAG_SECOND)
		else $error("split high byte overflow wrong");
	freeze_second_a: assert property (mode_second == tmc_pkg::MODE_SPLIT && !wr_go
			|=> $stable(count_low_byte_second) && $stable(count_high_byte_second))
		else $error("second timer moved in mode 3");
	stopped_first_a: assert property (!run_bit_first && !wr_go
			&& mode_first != tmc_pkg::MODE_SPLIT
			|=> $stable(count_low_byte_first) && $stable(count_high_byte_first))
		else $error("first timer counted while stopped");
endmodule : tmc_top
`default_nettype wire

// [verilog/tmc_pkg.sv]
// Package with register map, field positions and shared types of the dual timer
package tmc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_TIMER_MODE = 8'h00;
	localparam logic [7:0] OFF_TIMER_CONTROL = 8'h04;
	localparam logic [7:0] OFF_CLOCK_SPEED = 8'h08;
	localparam logic [7:0] OFF_LOW_FIRST = 8'h0c;
	localparam logic [7:0] OFF_LOW_SECOND = 8'h10;
	localparam logic [7:0] OFF_HIGH_FIRST = 8'h14;
	localparam logic [7:0] OFF_HIGH_SECOND = 8'h18;
	localparam logic [7:0] OFF_OPTION = 8'h1c;
	// Timer mode register fields (per timer nibble: gate, select, mode pair)
	localparam int MODE_SEL_LOW_FIRST = 0;
	localparam int MODE_SEL_HIGH_FIRST = 1;
	localparam int CT_SEL_FIRST = 2;
	localparam int GATE_FIRST = 3;
	localparam int MODE_SEL_LOW_SECOND = 4;
	localparam int MODE_SEL_HIGH_SECOND = 5;
	localparam int CT_SEL_SECOND = 6;
	localparam int GATE_SECOND = 7;
	// Timer control register fields
	localparam int RUN_BIT_FIRST = 4;
	localparam int OVERFLOW_FLAG_FIRST = 5;
	localparam int RUN_BIT_SECOND = 6;
	localparam int OVERFLOW_FLAG_SECOND = 7;
	// Clock speed register fields
	localparam int TURBO_SEL_FIRST = 3;
	localparam int TURBO_SEL_SECOND = 4;
	localparam int TURBO_SEL_THIRD = 5;
	// Option register field
	localparam int TWELVE_CLK_OPT = 3;
	// Reset values
	localparam logic [7:0] TIMER_MODE_RST = 8'h00;
	localparam logic [2:0] TURBO_RST = 3'h0;
	localparam logic [7:0] COUNT_RST = 8'h00;
	// Prescaler: twelve clocks per tick, half point for six
	localparam logic [3:0] PRESCALE_LAST = 4'hb;
	localparam logic [3:0] PRESCALE_HALF = 4'h5;
	// Mode encodings, upper select bit first
	localparam logic [1:0] MODE_13BIT = 2'h0;
	localparam logic [1:0] MODE_16BIT = 2'h1;
	localparam logic [1:0] MODE_RELOAD = 2'h2;
	localparam logic [1:0] MODE_SPLIT = 2'h3;
	localparam logic [4:0] LOW5_MAX = 5'h1f;
	localparam logic [7:0] BYTE_MAX = 8'hff;

	// One counting step: overflow and new byte pair
	typedef struct packed {
		logic ovf;
		logic [7:0] hi;
		logic [7:0] lo;
	} tmc_step_t;

	// APB response carried back to the master
	typedef struct packed {
		logic ready;
		logic slverr;
		logic [31:0] rdata;
	} tmc_apb_rsp_t;
endpackage : tmc_pkg

// [verilog/tmc_fall_detect.sv]
// Synchroniser and falling edge detector for an external count pin
`timescale 1ns/1ps
`default_nettype none
module tmc_fall_detect (
	input wire logic MCLK, // Core clock
	input wire logic RST_N, // Synchronous reset, active low
	input wire logic PIN, // Raw external pin
	output logic FALL // One-cycle pulse per falling edge
);
	logic meta;
	logic sync;
	logic prev;

	// Two-stage synchroniser, then previous sample for compare
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			meta <= 1'b1;
			sync <= 1'b1;
			prev <= 1'b1;
		end else begin
			meta <= PIN;
			sync <= meta;
			prev <= sync;
		end
	end

	// Edge pulse, at most one per sample
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			FALL <= 1'b0;
		end else begin
			FALL <= prev & ~sync;
		end
	end

	single_edge_a: assert property (@(posedge MCLK) disable iff (!RST_N) FALL |=> !FALL)
		else $error("count pin edge reported twice");
endmodule : tmc_fall_detect
`default_nettype wire

// [tb/dual_timer_counter_modes_tb.sv]
// Self-checking bench for the dual timer/counter block
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_modes_tb;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [1:0] ext = 2'h0;
	logic [1:0] cnt = 2'h3;
	logic [1:0] flag;
	int n_errors = 0;
	int checked = 0;

	// Core clock, 8 ns period
	always #4 mclk = ~mclk;

	tmc_top u_dut (
		.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.EXT_IRQ_PIN_FIRST(ext[0]), .EXT_IRQ_PIN_SECOND(ext[1]),
		.COUNT_PIN_FIRST(cnt[0]), .COUNT_PIN_SECOND(cnt[1]),
		.OVERFLOW_FLAG_FIRST(flag[0]), .OVERFLOW_FLAG_SECOND(flag[1])
	);

	// Compare and count
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Counts and verdict, then stop
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish

	// One APB transfer, held until pready, then one idle cycle
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] wd,
			output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, wd};
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_errors++;
			$display("Error pready expected 1 seen 0");
			tally_and_finish();
		end
		@(posedge mclk);
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		xfer(1'b1, a, d, r, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic e;
		xfer(1'b0, a, 8'h00, d, e);
	endtask : rd

	// Count advance over exactly 120 clocks
	task automatic rate(input logic [7:0] a, output logic [7:0] d);
		logic [31:0] x;
		logic [31:0] y;
		rd(a, x);
		repeat (116) @(posedge mclk);
		rd(a, y);
		d = y[7:0] - x[7:0];
	endtask : rate

	// Bounded wait on an overflow flag pin
	task automatic wait_flag(input int t);
		int n;
		n = 0;
		while (flag[t] !== 1'b1 && n < 100) begin
			@(posedge mclk);
			n++;
		end
		if (flag[t] !== 1'b1) begin
			n_errors++;
			$display("Error overflow flag expected 1 seen 0");
			tally_and_finish();
		end
	endtask : wait_flag

	task automatic t_regs();
		logic [31:0] d;
		logic e;
		for (int i = 0; i < 8; i++) begin
			rd(8'(i * 4), d);
			check("reset value", d, 32'h0);
		end
		xfer(1'b0, 8'h20, 8'h00, d, e);
		check("unmapped error", {31'h0, e}, 32'h1);
		check("unmapped data", d, 32'h0);
		wr(tmc_pkg::OFF_CLOCK_SPEED, 8'h38);
		rd(tmc_pkg::OFF_CLOCK_SPEED, d);
		check("turbo bits", d, 32'h38);
		wr(tmc_pkg::OFF_CLOCK_SPEED, 8'h00);
		wr(tmc_pkg::OFF_TIMER_CONTROL, 8'h0f);
		rd(tmc_pkg::OFF_TIMER_CONTROL, d);
		check("control low nibble", d, 32'h0);
		$display("Test registers done");
	endtask : t_regs

	// Time base per timer: 1/12, turbo 1/6, option forces 1/12
	task automatic t_rate();
		logic [7:0] d;
		for (int t = 0; t < 2; t++) begin
			wr(tmc_pkg::OFF_TIMER_MODE, 8'h11);
			wr(t ? tmc_pkg::OFF_TIMER_CONTROL : tmc_pkg::OFF_TIMER_CONTROL, t ? 8'h40 : 8'h10);
			rate(t ? tmc_pkg::OFF_LOW_SECOND : tmc_pkg::OFF_LOW_FIRST, d);
			check("rate twelve", {24'h0, d}, 32'd10);
			wr(tmc_pkg::OFF_CLOCK_SPEED, t ? 8'h10 : 8'h08);
			rate(t ? tmc_pkg::OFF_LOW_SECOND : tmc_pkg::OFF_LOW_FIRST, d);
			check("rate six", {24'h0, d}, 32'd20);
			wr(tmc_pkg::OFF_OPTION, 8'h08);
			rate(t ? tmc_pkg::OFF_LOW_SECOND : tmc_pkg::OFF_LOW_FIRST, d);
			check("rate option", {24'h0, d}, 32'd10);
			wr(tmc_pkg::OFF_OPTION, 8'h00);
			wr(tmc_pkg::OFF_CLOCK_SPEED, 8'h00);
			wr(tmc_pkg::OFF_TIMER_CONTROL, 8'h00);
		end
		$display("Test rate done");
	endtask : t_rate

	// Preload, run to the first wrap, stop and look at the bytes
	task automatic t_wrap(input int t, input logic [1:0] m, input logic [7:0] lo,
			input logic [7:0] hi, input logic [7:0] elo, input logic [7:0] ehi);
		logic [31:0] d;
		wr(tmc_pkg::OFF_TIMER_CONTROL, 8'h00);
		wr(tmc_pkg::OFF_TIMER_MODE, t ? {2'h0, m, 4'h0} : {6'h0, m});
		wr(t ? tmc_pkg::OFF_LOW_SECOND : tmc_pkg::OFF_LOW_FIRST, lo);
		wr(t ? tmc_pkg::OFF_HIGH_SECOND : tmc_pkg::OFF_HIGH_FIRST, hi);
		wr(tmc_pkg::OFF_TIMER_CONTROL, t ? 8'h40 : 8'h10);
		wait_flag(t);
		check("flag pin", {31'h0, flag[t]}, 32'h1);
		check("other flag", {31'h0, flag[1 - t]}, 32'h0);
		wr(tmc_pkg::OFF_TIMER_CONTROL, t ? 8'h80 : 8'h20);
		rd(t ? tmc_pkg::OFF_LOW_SECOND : tmc_pkg::OFF_LOW_FIRST, d);
		check("low after wrap", d, {24'h0, elo});
		rd(t ? tmc_pkg::OFF_HIGH_SECOND : tmc_pkg::OFF_HIGH_FIRST, d);
		check("high after wrap", d, {24'h0, ehi});
		rd(tmc_pkg::OFF_TIMER_CONTROL, d);
		check("flag bit", d, t ? 32'h80 : 32'h20);
		wr(tmc_pkg::OFF_TIMER_CONTROL, 8'h00);
		$display("Test wrap done");
	endtask : t_wrap

	// Gate pin holds or releases counting
	task automatic t_gate();
		logic [7:0] d;
		for (int t = 0; t < 2; t++) begin
			wr(tmc_pkg::OFF_TIMER_MODE, t ? 8'h90 : 8'h09);
			rate(t ? tmc_pkg::OFF_LOW_SECOND : tmc_pkg::OFF_LOW_FIRST, d);
			check("stopped", {24'h0, d}, 32'd0);
			wr(tmc_pkg::OFF_TIMER_CONTROL, t ? 8'h40 : 8'h10);
			rate(t ? tmc_pkg::OFF_LOW_SECOND : tmc_pkg::OFF_LOW_FIRST, d);
			check("gate low", {24'h0, d}, 32'd0);
			ext[t] <= 1'b1;
			rate(t ? tmc_pkg::OFF_LOW_SECOND : tmc_pkg::OFF_LOW_FIRST, d);
			check("gate high", {24'h0, d}, 32'd10);
			ext[t] <= 1'b0;
			wr(tmc_pkg::OFF_TIMER_CONTROL, 8'h00);
		end
		$display("Test gate done");
	endtask : t_gate

	// Counter mode: five falls on the count pin give five counts
	task automatic t_count();
		logic [31:0] d;
		for (int t = 0; t < 2; t++) begin
			wr(tmc_pkg::OFF_TIMER_MODE, t ? 8'h50 : 8'h05);
			wr(t ? tmc_pkg::OFF_LOW_SECOND : tmc_pkg::OFF_LOW_FIRST, 8'h00);
			wr(tmc_pkg::OFF_TIMER_CONTROL, t ? 8'h40 : 8'h10);
			repeat (5) begin
				cnt[t] <= 1'b0;
				repeat (4) @(posedge mclk);
				cnt[t] <= 1'b1;
				repeat (40) @(posedge mclk);
			end
			rd(t ? tmc_pkg::OFF_LOW_SECOND : tmc_pkg::OFF_LOW_FIRST, d);
			check("pin count", d, 32'd5);
			wr(tmc_pkg::OFF_TIMER_CONTROL, 8'h00);
		end
		$display("Test count done");
	endtask : t_count

	// Split first timer, second timer free running, then frozen
	task automatic t_split();
		logic [31:0] d;
		logic [7:0] r;
		wr(tmc_pkg::OFF_TIMER_MODE, 8'h03);
		wr(tmc_pkg::OFF_LOW_FIRST, 8'hfe);
		wr(tmc_pkg::OFF_HIGH_FIRST, 8'h10);
		wr(tmc_pkg::OFF_TIMER_CONTROL, 8'h10);
		wait_flag(0);
		check("split low flag", {30'h0, flag}, 32'h1);
		rd(tmc_pkg::OFF_HIGH_FIRST, d);
		check("split high idle", d, 32'h10);
		wr(tmc_pkg::OFF_HIGH_FIRST, 8'hff);
		wr(tmc_pkg::OFF_TIMER_CONTROL, 8'h40);
		wait_flag(1);
		check("split high flag", {30'h0, flag}, 32'h2);
		wr(tmc_pkg::OFF_TIMER_CONTROL, 8'h00);
		wr(tmc_pkg::OFF_TIMER_MODE, 8'h13);
		rate(tmc_pkg::OFF_LOW_SECOND, r);
		check("second free", {24'h0, r}, 32'd10);
		wr(tmc_pkg::OFF_TIMER_MODE, 8'h30);
		wr(tmc_pkg::OFF_LOW_SECOND, 8'h5a);
		wr(tmc_pkg::OFF_TIMER_CONTROL, 8'h40);
		rate(tmc_pkg::OFF_LOW_SECOND, r);
		check("frozen delta", {24'h0, r}, 32'd0);
		rd(tmc_pkg::OFF_LOW_SECOND, d);
		check("frozen value", d, 32'h5a);
		$display("Test split done");
	endtask : t_split

	// Main sequence
	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		t_regs();
		t_rate();
		t_wrap(0, tmc_pkg::MODE_13BIT, 8'hff, 8'hff, 8'he0, 8'h00);
		t_wrap(1, tmc_pkg::MODE_13BIT, 8'hff, 8'hff, 8'he0, 8'h00);
		t_wrap(0, tmc_pkg::MODE_16BIT, 8'hff, 8'hff, 8'h00, 8'h00);
		t_wrap(1, tmc_pkg::MODE_16BIT, 8'hff, 8'hff, 8'h00, 8'h00);
		t_wrap(0, tmc_pkg::MODE_RELOAD, 8'hff, 8'h80, 8'h80, 8'h80);
		t_wrap(1, tmc_pkg::MODE_RELOAD, 8'hff, 8'h80, 8'h80, 8'h80);
		t_gate();
		t_count();
		t_split();
		tally_and_finish();
	end
endmodule : dual_timer_counter_modes_tb
`default_nettype wire
